// ===== shared/cls_pkg.sv
// Shared constants and carrier types for the character LCD bus sequencer.
// Assumes a single 40 MHz clock and a 68xx-style LCD bus on the far side.
package cls_pkg;

    // Clock and bus timing
    localparam int CLS_CLK_PERIOD_NS = 25;
    localparam int CLS_STEP_NS = 500;
    // Least spacing rounds up to whole cycles
    localparam int CLS_STEP_CYCLES =
        (CLS_STEP_NS + CLS_CLK_PERIOD_NS - 1) / CLS_CLK_PERIOD_NS;

    // Synchroniser depth for inputs coming from the LCD pins
    localparam int CLS_SYNC_STAGES = 2;

    // Data bus layout
    localparam int CLS_DATA_W = 8;
    localparam int CLS_LOWER_W = 7;
    localparam int CLS_BUSY_BIT = 7;

    // Line levels
    localparam logic CLS_RW_WRITE = 1'b0;
    localparam logic CLS_RW_READ = 1'b1;
    localparam logic CLS_RS_INSTR = 1'b0;
    localparam logic CLS_RS_DATA = 1'b1;
    localparam logic CLS_EN_ON = 1'b1;
    localparam logic CLS_EN_OFF = 1'b0;

    // Counter and byte register reset values
    localparam logic [15:0] CLS_CNT16_ZERO = 16'h0000;
    localparam logic [7:0] CLS_BYTE_ZERO = 8'h00;

    // One queued entry: register select plus byte
    typedef struct packed {
        logic register_select;
        logic [CLS_DATA_W-1:0] data;
    } cls_entry_t;

    // Control lines of the LCD bus
    typedef struct packed {
        logic en;
        logic rw;
        logic register_select;
    } cls_ctrl_t;

    localparam cls_ctrl_t CLS_CTRL_IDLE = '{
        en: CLS_EN_OFF,
        rw: CLS_RW_READ,
        register_select: CLS_RS_INSTR
    };

endpackage

// ===== logic/cls_sync.sv
// Multi-bit two-flop synchroniser for the LCD input pins.
// Assumes each bit is independent; no word coherence is implied.
module cls_sync
    import cls_pkg::*;
#(
    parameter int WIDTH = CLS_DATA_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // First stage is read only by the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// ===== logic/cls_sequencer.sv
// LCD bus sequencer: moves queued bytes to a character LCD controller.
// Assumes a valid/ready source of entries on this clock and an LCD on
// slow asynchronous pins; pin tri-state resolution is done outside.
//
// Functional notes
// - The eight data lines are two-way and carry both characters and commands.
// - The top data line carries a data bit on writes and busy on reads.
// - Read/write select settles before the strobe rises, holds past its fall.
// - Register select picks the instruction or data register for every cycle.
// - A pending queue entry starts a bus sequence that sends it to the LCD.
// - Each cycle is a few ordered transitions paced by a loop counter.
// - Busy is read repeatedly before each new cycle until seen low.
// - Transitions are about 500 ns apart, many internal clocks each.
// - LCD inputs are oversampled and the busy branch uses those samples.
// - Queued writes run on their own; entry_ready stays low, holding off the source, until each write is done.
module cls_sequencer
    import cls_pkg::*;
#(
    parameter int STEP_CYCLES = CLS_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    // Entry source
    input wire logic entry_valid,
    input wire cls_entry_t entry,
    output logic entry_ready,
    // LCD control lines
    output logic lcd_en,
    output logic lcd_rw,
    output logic register_select,
    // LCD data lines, split into the busy line and the rest
    input wire logic busy_data_msb_i,
    output logic busy_data_msb_o,
    output logic busy_data_msb_oe,
    input wire logic [CLS_LOWER_W-1:0] lower_data_lines_i,
    output logic [CLS_LOWER_W-1:0] lower_data_lines_o,
    output logic lower_data_lines_oe,
    // Status
    output logic seq_idle,
    output logic [CLS_DATA_W-1:0] last_status,
    output logic [15:0] writes_done,
    output logic [15:0] last_poll_count
);

    localparam int CNT_W = $clog2(STEP_CYCLES + 1);

    // Busy samples need the strobe to outlast the synchroniser lag
    if (STEP_CYCLES < CLS_SYNC_STAGES + 1) begin : g_step_check
        $error("STEP_CYCLES must exceed the synchroniser depth");
    end

    // One-hot sequence states
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_POLL_SETUP = 8'h02,
        S_POLL_EN = 8'h04,
        S_POLL_END = 8'h08,
        S_WR_SETUP = 8'h10,
        S_WR_EN = 8'h20,
        S_WR_END = 8'h40,
        S_WR_HOLD = 8'h80
    } cls_state_t;

    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] SYNC_LAG = CNT_W'(CLS_SYNC_STAGES);

    // Synchronised view of all eight LCD data lines
    logic [CLS_DATA_W-1:0] pins_raw;
    logic [CLS_DATA_W-1:0] pins_sync;

    assign pins_raw = {busy_data_msb_i, lower_data_lines_i};

    cls_sync #(
        .WIDTH(CLS_DATA_W)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // Sequencer state
    cls_state_t state_q;
    cls_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    cls_entry_t hold_q;
    cls_entry_t hold_d;
    logic busy_seen_q;
    logic busy_seen_d;
    logic step_done;

    // Output registers
    cls_ctrl_t ctrl_q;
    cls_ctrl_t ctrl_d;
    logic [CLS_DATA_W-1:0] dout_q;
    logic [CLS_DATA_W-1:0] dout_d;
    logic oe_q;
    logic oe_d;
    logic ready_q;
    logic ready_d;
    logic idle_q;
    logic idle_d;
    logic [CLS_DATA_W-1:0] status_q;
    logic [CLS_DATA_W-1:0] status_d;
    logic [15:0] writes_q;
    logic [15:0] writes_d;
    logic [15:0] polls_q;
    logic [15:0] polls_d;

    // Loop counter paces every transition except the exit from S_IDLE
    assign step_done = (cnt_q == STEP_LAST);

    // Next state and pacing
    always_comb begin
        state_d = state_q;
        cnt_d = step_done ? CNT_ZERO : cnt_q + CNT_ONE;
        hold_d = hold_q;
        busy_seen_d = busy_seen_q;
        status_d = status_q;
        writes_d = writes_q;
        polls_d = polls_q;
        case (state_q)
            S_IDLE: begin
                cnt_d = CNT_ZERO;
                // Entry taken on the handshake, then run alone
                if (entry_valid && ready_q) begin
                    hold_d = entry;
                    polls_d = CLS_CNT16_ZERO;
                    state_d = S_POLL_SETUP;
                end
            end
            S_POLL_SETUP: begin
                busy_seen_d = 1'b0;
                if (step_done) begin
                    state_d = S_POLL_EN;
                end
            end
            S_POLL_EN: begin
                // Early samples still carry pre-strobe pin levels, so
                // only the settled ones count as busy
                if (pins_sync[CLS_BUSY_BIT] && cnt_q >= SYNC_LAG) begin
                    busy_seen_d = 1'b1;
                end
                if (step_done) begin
                    status_d = pins_sync;
                    polls_d = polls_q + 16'h0001;
                    state_d = S_POLL_END;
                end
            end
            S_POLL_END: begin
                // Any settled busy sample forces another poll
                if (step_done) begin
                    state_d = busy_seen_q ? S_POLL_SETUP : S_WR_SETUP;
                end
            end
            S_WR_SETUP: begin
                if (step_done) begin
                    state_d = S_WR_EN;
                end
            end
            S_WR_EN: begin
                if (step_done) begin
                    state_d = S_WR_END;
                end
            end
            S_WR_END: begin
                if (step_done) begin
                    state_d = S_WR_HOLD;
                end
            end
            S_WR_HOLD: begin
                if (step_done) begin
                    writes_d = writes_q + 16'h0001;
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
                cnt_d = CNT_ZERO;
            end
        endcase
    end

    // Pin levels are decoded from the next state so that they leave
    // flip-flops aligned with the state change.
    always_comb begin
        ctrl_d = CLS_CTRL_IDLE;
        dout_d = dout_q;
        oe_d = 1'b0;
        ready_d = 1'b0;
        idle_d = 1'b0;
        case (state_d)
            S_IDLE: begin
                // Ready only after the previous entry fully left
                ready_d = ~(entry_valid && ready_q);
                idle_d = ready_d;
            end
            S_POLL_SETUP: begin
                // Busy read uses the instruction register
                ctrl_d.rw = CLS_RW_READ;
                ctrl_d.register_select = CLS_RS_INSTR;
            end
            S_POLL_EN: begin
                // Drivers released while the LCD drives the bus
                ctrl_d.rw = CLS_RW_READ;
                ctrl_d.register_select = CLS_RS_INSTR;
                ctrl_d.en = CLS_EN_ON;
            end
            S_POLL_END: begin
                // Read level held past the falling strobe
                ctrl_d.rw = CLS_RW_READ;
                ctrl_d.register_select = CLS_RS_INSTR;
            end
            S_WR_SETUP: begin
                // Select and data settle a step before the strobe
                ctrl_d.rw = CLS_RW_WRITE;
                ctrl_d.register_select = hold_q.register_select;
                dout_d = hold_q.data;
                oe_d = 1'b1;
            end
            S_WR_EN: begin
                ctrl_d.rw = CLS_RW_WRITE;
                ctrl_d.register_select = hold_q.register_select;
                ctrl_d.en = CLS_EN_ON;
                dout_d = hold_q.data;
                oe_d = 1'b1;
            end
            S_WR_END: begin
                // Strobe falls with write level and data still held
                ctrl_d.rw = CLS_RW_WRITE;
                ctrl_d.register_select = hold_q.register_select;
                dout_d = hold_q.data;
                oe_d = 1'b1;
            end
            S_WR_HOLD: begin
                // Hold time after the strobe; drivers still on
                ctrl_d.rw = CLS_RW_WRITE;
                ctrl_d.register_select = hold_q.register_select;
                dout_d = hold_q.data;
                oe_d = 1'b1;
            end
            default: begin
                ctrl_d = CLS_CTRL_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Strobe low, drivers off, waiting for an entry
            state_q <= S_IDLE;
            cnt_q <= '0;
            hold_q <= '0;
            busy_seen_q <= 1'b0;
            ctrl_q <= CLS_CTRL_IDLE;
            dout_q <= CLS_BYTE_ZERO;
            oe_q <= 1'b0;
            ready_q <= 1'b0;
            idle_q <= 1'b0;
            status_q <= CLS_BYTE_ZERO;
            writes_q <= CLS_CNT16_ZERO;
            polls_q <= CLS_CNT16_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            busy_seen_q <= busy_seen_d;
            ctrl_q <= ctrl_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            ready_q <= ready_d;
            idle_q <= idle_d;
            status_q <= status_d;
            writes_q <= writes_d;
            polls_q <= polls_d;
        end
    end

    // All outputs straight from flip-flops; one enable for all eight lines
    // keeps the bus from ever being half driven.
    assign lcd_en = ctrl_q.en;
    assign lcd_rw = ctrl_q.rw;
    assign register_select = ctrl_q.register_select;
    assign busy_data_msb_o = dout_q[CLS_BUSY_BIT];
    assign busy_data_msb_oe = oe_q;
    assign lower_data_lines_o = dout_q[CLS_LOWER_W-1:0];
    assign lower_data_lines_oe = oe_q;
    assign entry_ready = ready_q;
    assign seq_idle = idle_q;
    assign last_status = status_q;
    assign writes_done = writes_q;
    assign last_poll_count = polls_q;

endmodule

// ===== bench/cls_seq_monitor.sv
// Port checker for the LCD bus sequencer.
// Assumes a bind onto cls_sequencer; sees only its ports.
module cls_seq_monitor
    import cls_pkg::*;
#(
    parameter int STEP_CYCLES = CLS_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic entry_valid,
    input wire cls_entry_t entry,
    input wire logic entry_ready,
    input wire logic lcd_en,
    input wire logic lcd_rw,
    input wire logic register_select,
    input wire logic busy_data_msb_o,
    input wire logic busy_data_msb_oe,
    input wire logic [CLS_LOWER_W-1:0] lower_data_lines_o,
    input wire logic lower_data_lines_oe,
    input wire logic seq_idle,
    input wire logic [CLS_DATA_W-1:0] last_status,
    input wire logic [15:0] writes_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] en_cnt_q, en_cnt_d;
    cls_entry_t ent_q, ent_d;
    logic take;
    assign take = entry_valid && entry_ready;
    always_comb begin
        en_cnt_d = lcd_en ? en_cnt_q + 16'h0001 : CLS_CNT16_ZERO;
        ent_d = take ? entry : ent_q;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            en_cnt_q <= CLS_CNT16_ZERO;
            ent_q <= '0;
        end else begin
            en_cnt_q <= en_cnt_d;
            ent_q <= ent_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    rw_setup_a: assert property ($rose(lcd_en) |->
        $stable(lcd_rw) && $stable(register_select))
        else $error("rw moved at strobe rise");
    rw_hold_a: assert property ($fell(lcd_en) |->
        $stable(lcd_rw) ##1 $stable(lcd_rw)) else $error("rw moved at fall");
    strobe_width_a: assert property ($fell(lcd_en) |->
        en_cnt_q == 16'(STEP_CYCLES)) else $error("strobe width wrong");
    read_release_a: assert property (lcd_rw == CLS_RW_READ |->
        !busy_data_msb_oe && !lower_data_lines_oe)
        else $error("data driven in read");
    write_byte_a: assert property ($rose(lcd_en) && !lcd_rw |->
        busy_data_msb_oe && register_select == ent_q.register_select &&
        {busy_data_msb_o, lower_data_lines_o} == ent_q.data)
        else $error("write byte wrong");
    take_start_a: assert property (take |=> !entry_ready
        ##[0:40] lcd_en) else $error("no cycle after take");
    idle_quiet_a: assert property (seq_idle |-> entry_ready &&
        !lcd_en && !lower_data_lines_oe) else $error("idle not quiet");
    busy_repoll_a: assert property ($fell(lcd_en) && lcd_rw
        ##1 last_status[CLS_BUSY_BIT] |-> lcd_rw [*4])
        else $error("no repoll on busy");
    done_count_a: assert property ($rose(entry_ready) &&
        $past(lcd_rw) == CLS_RW_WRITE |->
        writes_done == $past(writes_done) + 16'h0001)
        else $error("write count wrong");
    take_c: cover property (take);
    repoll_c: cover property ($fell(lcd_en) && lcd_rw ##1 last_status[7]);
    write_c: cover property ($rose(lcd_en) && !lcd_rw);
endmodule

// ===== bench/cls_lcd_model.sv
// Character LCD controller model on the sequencer's far side.
// Assumes the bench resolves the shared data lines from all enables.
module cls_lcd_model
    import cls_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic lcd_en,
    input wire logic lcd_rw,
    input wire logic register_select,
    input wire logic [7:0] bus_in,
    input wire logic [3:0] busy_polls,
    output logic [7:0] drv,
    output logic drv_oe,
    output logic [7:0] wr_data,
    output logic wr_rs,
    output logic [15:0] wr_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic en_q;
    logic [3:0] left_q;
    logic fall;
    assign fall = en_q && !lcd_en;
    // Drives only while a read strobe is high
    assign drv_oe = lcd_en && lcd_rw == CLS_RW_READ;
    assign drv = {left_q != 4'h0, wr_cnt[6:0]};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 1'b0;
            left_q <= 4'h0;
            wr_data <= 8'h00;
            wr_rs <= 1'b0;
            wr_cnt <= 16'h0000;
        end else begin
            en_q <= lcd_en;
            if (fall && lcd_rw == CLS_RW_WRITE) begin
                // Byte is latched on the falling strobe
                wr_data <= bus_in;
                wr_rs <= register_select;
                wr_cnt <= wr_cnt + 16'h0001;
                left_q <= busy_polls;
            end else if (fall && left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the LCD bus sequencer and LCD model.
// Assumes a short step parameter so each LCD cycle stays brief.
module tb_top
    import cls_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int S = 3;
    logic clock = 1'b0, arst_n = 1'b0, entry_valid = 1'b0;
    cls_entry_t entry = '0;
    logic entry_ready, lcd_en, lcd_rw, rs, mo, moe, loe, seq_idle, drv_oe;
    logic [6:0] lo;
    logic [7:0] last_status, drv, wr_data, bus, bus_last_q = 8'h00;
    logic [15:0] writes_done, polls, wr_cnt, exp_n = 16'h0000;
    logic wr_rs;
    logic [3:0] busy_polls = 4'h0, busy_prev = 4'h0;
    int miscompares = 0, samples_checked = 0;
    always #12.5 clock = ~clock;
    // Released lines float, so they show a changing pattern
    always_comb begin
        bus = drv_oe ? drv : ~bus_last_q;
        if (moe) bus[7] = mo;
        if (loe) bus[6:0] = lo;
    end
    always_ff @(posedge clock) bus_last_q <= bus;
    cls_sequencer #(.STEP_CYCLES(S)) DUT (.clock(clock), .arst_n(arst_n),
        .entry_valid(entry_valid), .entry(entry), .entry_ready(entry_ready),
        .lcd_en(lcd_en), .lcd_rw(lcd_rw), .register_select(rs),
        .busy_data_msb_i(bus[7]), .busy_data_msb_o(mo),
        .busy_data_msb_oe(moe), .lower_data_lines_i(bus[6:0]),
        .lower_data_lines_o(lo), .lower_data_lines_oe(loe),
        .seq_idle(seq_idle), .last_status(last_status),
        .writes_done(writes_done), .last_poll_count(polls));
    cls_lcd_model LCD (.clock(clock), .arst_n(arst_n), .lcd_en(lcd_en),
        .lcd_rw(lcd_rw), .register_select(rs), .bus_in(bus),
        .busy_polls(busy_polls), .drv(drv), .drv_oe(drv_oe),
        .wr_data(wr_data), .wr_rs(wr_rs), .wr_cnt(wr_cnt));
    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, g);
        samples_checked++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic take_entry(input logic r, input logic [7:0] d,
        input logic [3:0] p);
        busy_polls <= p;
        entry_valid <= 1'b1;
        entry <= '{register_select: r, data: d};
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (entry_ready === 1'b1) begin
                entry_valid <= 1'b0;
                return;
            end
        end
        miscompares++;
        close_out();
    endtask
    task automatic send(input logic r, input logic [7:0] d,
        input logic [3:0] p);
        take_entry(r, d, p);
        // Ready still reads high in the take step, so look from the next edge
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            if (entry_ready === 1'b1)
                break;
        end
        if (entry_ready !== 1'b1) begin
            miscompares++;
            close_out();
        end
        @(negedge clock);
        exp_n++;
        chk("lcd byte", {8'h00, d}, {8'h00, wr_data});
        chk("lcd reg", {15'h0, r}, {15'h0, wr_rs});
        chk("writes", exp_n, writes_done);
        chk("lcd writes", exp_n, wr_cnt);
        chk("busy seen", 16'h0, {15'h0, last_status[7]});
        chk("status", {9'h0, exp_n[6:0] - 7'h01},
            {9'h0, last_status[6:0]});
        // The model stays busy after a write for the count given with it
        chk("polls", {12'h0, busy_prev} + 16'h1, polls);
        busy_prev = p;
        @(posedge clock);
    endtask
    task automatic t_reset();
        @(negedge clock);
        chk("rst en", 16'h0, {15'h0, lcd_en});
        chk("rst oe", 16'h0, {14'h0, moe, loe});
        chk("rst ready", 16'h0, {15'h0, entry_ready});
    endtask
    task automatic t_idle();
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk("idle", 16'h3, {14'h0, seq_idle, entry_ready});
        chk("idle en", 16'h0, {15'h0, lcd_en});
        @(posedge clock);
    endtask
    task automatic t_batch();
        for (int k = 0; k < 3; k++)
            send(CLS_RS_DATA, 8'h40 + 8'(k), 4'(k));
    endtask
    task automatic t_midreset();
        take_entry(CLS_RS_DATA, 8'hc3, 4'h0);
        repeat (2 * S + 2) @(posedge clock);
        arst_n <= 1'b0;
        t_reset();
        @(posedge clock);
        arst_n <= 1'b1;
        exp_n = 16'h0000;
        busy_prev = 4'h0;
        t_idle();
        send(CLS_RS_INSTR, 8'h01, 4'h1);
    endtask
    initial begin
        repeat (11) @(posedge clock);
        t_reset();
        @(posedge clock);
        arst_n <= 1'b1;
        t_idle();
        send(CLS_RS_INSTR, 8'h38, 4'h0);
        send(CLS_RS_DATA, 8'ha5, 4'h2);
        t_batch();
        t_midreset();
        close_out();
    end
endmodule
bind cls_sequencer cls_seq_monitor #(.STEP_CYCLES(STEP_CYCLES)) MON (
    .clock(clock), .arst_n(arst_n), .entry_valid(entry_valid),
    .entry(entry), .entry_ready(entry_ready), .lcd_en(lcd_en),
    .lcd_rw(lcd_rw), .register_select(register_select),
    .busy_data_msb_o(busy_data_msb_o), .busy_data_msb_oe(busy_data_msb_oe),
    .lower_data_lines_o(lower_data_lines_o),
    .lower_data_lines_oe(lower_data_lines_oe), .seq_idle(seq_idle),
    .last_status(last_status), .writes_done(writes_done));
